// *** common/cstz_pkg.sv ***
// types shared by the charge safety timer and temperature zone block
package cstz_pkg;

  typedef enum logic [2:0] {
    CSTZ_Z_NORMAL = 3'b000,
    CSTZ_Z_COLD   = 3'b001,
    CSTZ_Z_COOL   = 3'b010,
    CSTZ_Z_WARM   = 3'b011,
    CSTZ_Z_HOT    = 3'b100
  } cstz_zone_e;

  typedef enum logic [2:0] {
    CSTZ_S_IDLE    = 3'b000,
    CSTZ_S_TRICKLE = 3'b001,
    CSTZ_S_PRE     = 3'b010,
    CSTZ_S_FAST    = 3'b011,
    CSTZ_S_TAPER   = 3'b100,
    CSTZ_S_TOPOFF  = 3'b110,
    CSTZ_S_DONE    = 3'b111
  } cstz_stage_e;

  typedef enum logic [1:0] {
    CSTZ_I_SUSPEND = 2'b00,
    CSTZ_I_20      = 2'b01,
    CSTZ_I_40      = 2'b10,
    CSTZ_I_FULL    = 2'b11
  } cstz_scale_e;

endpackage

// *** common/cstz_regs.svh ***
// register offsets, field positions, reset values and timing figures
`ifndef CSTZ_REGS_SVH
`define CSTZ_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CSTZ_ADDR_CTRL0   4'h0
`define CSTZ_ADDR_CTRL1   4'h1
`define CSTZ_ADDR_STATUS  4'h2
`define CSTZ_ADDR_FLAGS   4'h3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CSTZ_C0_CHARGE_ALLOW  0
`define CSTZ_C0_TRICKLE_ON    1
`define CSTZ_C0_PRECHARGE_ON  2
`define CSTZ_C0_FAST_ON       3
`define CSTZ_C0_SLOW_REG      4
`define CSTZ_C0_PRE_SEL       5
`define CSTZ_C0_FAST_SET_LO   6
`define CSTZ_C1_COOL_SCALE_LO 0
`define CSTZ_C1_TERM_ALLOW    2
`define CSTZ_C1_TS_BYPASS     3
`define CSTZ_C1_TEMP_MASK     4
`define CSTZ_C1_REVERSE_ON    5
`define CSTZ_FL_TIMER         4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CSTZ_CTRL0_RST 8'h9f
`define CSTZ_CTRL1_RST 8'h05

// ----------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------
`define CSTZ_CLK_PERIOD_NS 20
`define CSTZ_TICK_TIME_NS  1000000000
`define CSTZ_ALERT_TIME_NS 256000
`define CSTZ_TRICKLE_S     3600
`define CSTZ_PRE_LONG_S    7200
`define CSTZ_PRE_SHORT_S   1800
`define CSTZ_FAST_0_S      18000
`define CSTZ_FAST_1_S      28800
`define CSTZ_FAST_2_S      43200
`define CSTZ_FAST_3_S      86400

`endif

// *** rtl/cstz_safety_timer.sv ***
// charge safety timers with temperature zone qualification
//
// Notes on behaviour
// - fast timer expiry sets fault, pulses alert
// - trickle timer fixed at one hour
// - pre-charge two hours default, or half hour
// - fast duration host programmable, twelve hours default
// - enable bit low disables that stage timer
// - enable restarts timer; stage start starts counting
// - regulation halves the timer rate
// - slow-count bit low disables half rate
// - disabling half rate waits for regulation end
// - fault or supplement freezes count, resumes later
// - cycle stop and restart clears timer
// - all three timers share suspend/reset/half rules
// - fast cleared: restart, pre/fast moves, setting change
// - pre cleared: restart, neighbour moves, select change
// - trickle cleared: restart, trickle/pre moves
// - charge only between cold and hot
// - cool zone current 20, 40, 100% or suspend
// - termination same in every zone when allowed
// - zone suspend freezes, scaled current halves rate
// - bypass means temperature good, zone reads 000
// - zone change updates state, alert; entering a non-normal zone sets its flag
// - reverse output stops outside window, recovers
// - alert pulse is low for 256 us
`timescale 1ns/1ps
`include "cstz_regs.svh"

module cstz_safety_timer
  import cstz_pkg::*;
#(
  parameter int CNT_W         = 17,
  parameter int TICK_CYCLES   = `CSTZ_TICK_TIME_NS / `CSTZ_CLK_PERIOD_NS,
  parameter int ALERT_CYCLES  = `CSTZ_ALERT_TIME_NS / `CSTZ_CLK_PERIOD_NS,
  parameter int TRICKLE_TICKS = `CSTZ_TRICKLE_S,
  parameter int PRE_LONG      = `CSTZ_PRE_LONG_S,
  parameter int PRE_SHORT     = `CSTZ_PRE_SHORT_S,
  parameter int FAST_0        = `CSTZ_FAST_0_S,
  parameter int FAST_1        = `CSTZ_FAST_1_S,
  parameter int FAST_2        = `CSTZ_FAST_2_S,
  parameter int FAST_3        = `CSTZ_FAST_3_S
) (
  input  wire logic       MCLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [3:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic [2:0] CHG_STAGE_I,
  input  wire logic       CE_N_I,
  input  wire logic       RECHARGE_I,
  input  wire logic       VIN_REG_I,
  input  wire logic       INPUT_CURRENT_LIMIT_ACTIVE_I,
  input  wire logic       THERMAL_REG_I,
  input  wire logic       CHARGE_FAULT_I,
  input  wire logic       SUPPLEMENT_I,
  input  wire logic       TS_COLD_I,
  input  wire logic       COOL_THRESHOLD_SEL_I,
  input  wire logic       WARM_THRESHOLD_SEL_I,
  input  wire logic       TS_HOT_I,
  input  wire logic [2:0] SOURCE_TYPE_I,
  output logic            HOST_ALERT_N_O,
  output logic            CHARGE_SUSPEND_O,
  output logic      [1:0] CURRENT_SCALE_O,
  output logic            TERM_ALLOW_O,
  output logic            REVERSE_SWITCH_O,
  output logic      [2:0] INPUT_SOURCE_TYPE_O,
  output logic            TIMER_EXPIRED_FAULT_O
);

  localparam int PRE_W   = $clog2(TICK_CYCLES + 1);
  localparam int ALERT_W = $clog2(ALERT_CYCLES + 1);

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  // ----------------------------------------------------------------------
  // stage decode
  // ----------------------------------------------------------------------
  // 0 none, 1 trickle, 2 pre-charge, 3 fast (cc, cv and top-off)
  function automatic logic [1:0] stage_idx(input logic [2:0] s);
    case (cstz_stage_e'(s))
      CSTZ_S_TRICKLE: stage_idx = 2'd1;
      CSTZ_S_PRE:     stage_idx = 2'd2;
      CSTZ_S_FAST,
      CSTZ_S_TAPER,
      CSTZ_S_TOPOFF:  stage_idx = 2'd3;
      default:        stage_idx = 2'd0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]       ctrl0, next_ctrl0;
  logic [7:0]       ctrl1, next_ctrl1;
  logic [4:0]       flags, next_flags;
  logic [7:0]       rdata, next_rdata;
  logic [PRE_W-1:0] pre_cnt, next_pre_cnt;
  logic             half_ph, next_half_ph;
  logic             slow_hold, next_slow_hold;
  logic             charge_en_q, next_charge_en_q;
  logic [2:0]       stage_q, next_stage_q;
  logic [2:0]       on_q, next_on_q;
  logic [1:0]       fts_q, next_fts_q;
  logic             psel_q, next_psel_q;
  logic [CNT_W-1:0] cnt [3];
  logic [CNT_W-1:0] next_cnt [3];
  logic             tfault, next_tfault;
  cstz_zone_e       zone_q, next_zone_q;
  logic [ALERT_W-1:0] alert_cnt, next_alert_cnt;
  logic             alert_n, next_alert_n;
  logic             susp_o, next_susp_o;
  logic [1:0]       scale_o, next_scale_o;
  logic             term_o, next_term_o;
  logic             rev_o, next_rev_o;
  logic [2:0]       src_o, next_src_o;

  // ----------------------------------------------------------------------
  // combinational terms
  // ----------------------------------------------------------------------
  logic [2:0]       on;
  logic [1:0]       fts;
  logic             psel, slow_cfg, bypass, tmask, rev_on;
  logic [1:0]       cool_scale;
  logic             charge_en, restart, tick, regulating, slow_eff;
  logic             half, suspend, adv, zone_chg, alert_evt, otg_stop;
  logic             zone_half, zone_susp, tp_move, pf_move;
  logic [1:0]       cur, prv;
  logic [2:0]       clr, expire;
  logic [CNT_W-1:0] dur [3];
  cstz_zone_e       zone_raw;

  assign on         = {ctrl0[`CSTZ_C0_FAST_ON], ctrl0[`CSTZ_C0_PRECHARGE_ON],
                       ctrl0[`CSTZ_C0_TRICKLE_ON]};
  assign fts        = ctrl0[`CSTZ_C0_FAST_SET_LO +: 2];
  assign psel       = ctrl0[`CSTZ_C0_PRE_SEL];
  assign slow_cfg   = ctrl0[`CSTZ_C0_SLOW_REG];
  assign cool_scale = ctrl1[`CSTZ_C1_COOL_SCALE_LO +: 2];
  assign bypass     = ctrl1[`CSTZ_C1_TS_BYPASS];
  assign tmask      = ctrl1[`CSTZ_C1_TEMP_MASK];
  assign rev_on     = ctrl1[`CSTZ_C1_REVERSE_ON];

  always_comb begin
    // pin low and bit high together make a charge cycle
    charge_en = ctrl0[`CSTZ_C0_CHARGE_ALLOW] & ~CE_N_I;
    restart   = (charge_en & ~charge_en_q) | RECHARGE_I;
    cur       = stage_idx(CHG_STAGE_I);
    prv       = stage_idx(stage_q);
    tp_move   = (cur == 2'd1 && prv == 2'd2) || (cur == 2'd2 && prv == 2'd1);
    pf_move   = (cur == 2'd2 && prv == 2'd3) || (cur == 2'd3 && prv == 2'd2);
    // temperature zone, cold and hot take priority over cool and warm
    if (bypass) begin
      zone_raw = CSTZ_Z_NORMAL;
    end else if (TS_COLD_I) begin
      zone_raw = CSTZ_Z_COLD;
    end else if (TS_HOT_I) begin
      zone_raw = CSTZ_Z_HOT;
    end else if (COOL_THRESHOLD_SEL_I) begin
      zone_raw = CSTZ_Z_COOL;
    end else if (WARM_THRESHOLD_SEL_I) begin
      zone_raw = CSTZ_Z_WARM;
    end else begin
      zone_raw = CSTZ_Z_NORMAL;
    end
    zone_susp = (zone_q == CSTZ_Z_COLD) || (zone_q == CSTZ_Z_HOT) ||
                (zone_q == CSTZ_Z_COOL && cool_scale == CSTZ_I_SUSPEND);
    zone_half = (zone_q == CSTZ_Z_COOL) &&
                (cool_scale == CSTZ_I_20 || cool_scale == CSTZ_I_40);
    zone_chg  = (zone_raw != zone_q) && !bypass;
    otg_stop  = rev_on && !bypass &&
                (zone_raw == CSTZ_Z_COLD || zone_raw == CSTZ_Z_HOT);
    // a disable made during regulation only lands once it ends
    regulating = VIN_REG_I | INPUT_CURRENT_LIMIT_ACTIVE_I | THERMAL_REG_I;
    slow_eff   = regulating ? slow_hold : slow_cfg;
    half       = (regulating & slow_eff) | zone_half;
    // freezing keeps the count, so the half-rate setting is moot here
    suspend    = CHARGE_FAULT_I | SUPPLEMENT_I | zone_susp | tfault |
                 ~charge_en;
    tick       = (pre_cnt == PRE_W'(TICK_CYCLES - 1));
    adv        = tick & ~suspend & (~half | half_ph);
    // durations
    dur[0] = CNT_W'(TRICKLE_TICKS);
    dur[1] = psel ? CNT_W'(PRE_SHORT) : CNT_W'(PRE_LONG);
    case (fts)
      2'b00:   dur[2] = CNT_W'(FAST_0);
      2'b01:   dur[2] = CNT_W'(FAST_1);
      2'b10:   dur[2] = CNT_W'(FAST_2);
      default: dur[2] = CNT_W'(FAST_3);
    endcase
    // clear events per stage timer
    clr[0] = restart | tp_move | (on[0] & ~on_q[0]);
    clr[1] = restart | tp_move | pf_move | (psel != psel_q) |
             (on[1] & ~on_q[1]);
    clr[2] = restart | pf_move | (fts != fts_q) |
             (on[2] & ~on_q[2]);
  end

  // ----------------------------------------------------------------------
  // stage timers
  // ----------------------------------------------------------------------
  always_comb begin
    next_pre_cnt     = tick ? '0 : pre_cnt + PRE_W'(1);
    next_half_ph     = (tick && !suspend) ? ~half_ph : half_ph;
    next_slow_hold   = slow_eff;
    next_charge_en_q = charge_en;
    next_stage_q     = CHG_STAGE_I;
    next_on_q        = on;
    next_fts_q       = fts;
    next_psel_q      = psel;
    for (int i = 0; i < 3; i++) begin
      expire[i]   = 1'b0;
      next_cnt[i] = cnt[i];
      if (clr[i] || !on[i]) begin
        next_cnt[i] = '0;
      end else if (adv && cur == 2'(i + 1) && cnt[i] < dur[i]) begin
        next_cnt[i] = cnt[i] + CNT_W'(1);
        expire[i]   = (cnt[i] == dur[i] - CNT_W'(1));
      end
    end
    // restart clears every count too, so no expiry can land in that cycle
    next_tfault = (|expire) | (tfault & ~restart);
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      pre_cnt     <= '0;
      half_ph     <= 1'b0;
      slow_hold   <= 1'b1;
      charge_en_q <= 1'b0;
      stage_q     <= 3'h0;
      on_q        <= 3'h7;
      fts_q       <= 2'h2;
      psel_q      <= 1'b0;
      tfault      <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      pre_cnt     <= next_pre_cnt;
      half_ph     <= next_half_ph;
      slow_hold   <= next_slow_hold;
      charge_en_q <= next_charge_en_q;
      stage_q     <= next_stage_q;
      on_q        <= next_on_q;
      fts_q       <= next_fts_q;
      psel_q      <= next_psel_q;
      tfault      <= next_tfault;
      for (int i = 0; i < 3; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers, zones, alert and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    if (REG_WR_I && REG_ADDR_I == `CSTZ_ADDR_CTRL0) begin
      next_ctrl0 = REG_WDATA_I;
    end else if (REG_WR_I && REG_ADDR_I == `CSTZ_ADDR_CTRL1) begin
      next_ctrl1 = {2'b00, REG_WDATA_I[5:0]};
    end
    next_rdata = 8'h00;
    if (!REG_RD_I) begin
      next_rdata = 8'h00;
    end else if (REG_ADDR_I == `CSTZ_ADDR_CTRL0) begin
      next_rdata = ctrl0;
    end else if (REG_ADDR_I == `CSTZ_ADDR_CTRL1) begin
      next_rdata = ctrl1;
    end else if (REG_ADDR_I == `CSTZ_ADDR_STATUS) begin
      next_rdata = {2'b00, half, suspend, tfault, zone_q};
    end else if (REG_ADDR_I == `CSTZ_ADDR_FLAGS) begin
      next_rdata = {3'b000, flags};
    end
    // flags clear on read, a new event in that cycle wins
    next_flags = (REG_RD_I && REG_ADDR_I == `CSTZ_ADDR_FLAGS) ? 5'h00 : flags;
    if (zone_chg) begin
      case (zone_raw)
        CSTZ_Z_COLD: next_flags[0] = 1'b1;
        CSTZ_Z_COOL: next_flags[1] = 1'b1;
        CSTZ_Z_WARM: next_flags[2] = 1'b1;
        CSTZ_Z_HOT:  next_flags[3] = 1'b1;
        default:     next_flags[0] = next_flags[0];
      endcase
    end
    if (|expire) begin
      next_flags[`CSTZ_FL_TIMER] = 1'b1;
    end
    next_zone_q = zone_raw;
    // a new event restarts the pulse rather than queueing a second one
    alert_evt = (zone_chg & ~tmask) | (|expire);
    if (alert_evt) begin
      next_alert_cnt = ALERT_W'(ALERT_CYCLES);
    end else if (alert_cnt != '0) begin
      next_alert_cnt = alert_cnt - ALERT_W'(1);
    end else begin
      next_alert_cnt = '0;
    end
    next_alert_n = (next_alert_cnt == '0);
    next_susp_o  = suspend;
    case (zone_q)
      CSTZ_Z_COOL:             next_scale_o = cool_scale;
      CSTZ_Z_COLD, CSTZ_Z_HOT: next_scale_o = CSTZ_I_SUSPEND;
      default:                 next_scale_o = CSTZ_I_FULL;
    endcase
    next_term_o = ctrl1[`CSTZ_C1_TERM_ALLOW];
    next_rev_o  = rev_on & ~otg_stop;
    next_src_o  = otg_stop ? 3'h0 : SOURCE_TYPE_I;
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ctrl0     <= `CSTZ_CTRL0_RST;
      ctrl1     <= `CSTZ_CTRL1_RST;
      flags     <= 5'h00;
      rdata     <= 8'h00;
      zone_q    <= CSTZ_Z_NORMAL;
      alert_cnt <= '0;
      alert_n   <= 1'b1;
      susp_o    <= 1'b1;
      scale_o   <= 2'h3;
      term_o    <= 1'b1;
      rev_o     <= 1'b0;
      src_o     <= 3'h0;
    end else begin
      ctrl0     <= next_ctrl0;
      ctrl1     <= next_ctrl1;
      flags     <= next_flags;
      rdata     <= next_rdata;
      zone_q    <= next_zone_q;
      alert_cnt <= next_alert_cnt;
      alert_n   <= next_alert_n;
      susp_o    <= next_susp_o;
      scale_o   <= next_scale_o;
      term_o    <= next_term_o;
      rev_o     <= next_rev_o;
      src_o     <= next_src_o;
    end
  end

  assign REG_RDATA_O           = rdata;
  assign HOST_ALERT_N_O        = alert_n;
  assign CHARGE_SUSPEND_O      = susp_o;
  assign CURRENT_SCALE_O       = scale_o;
  assign TERM_ALLOW_O          = term_o;
  assign REVERSE_SWITCH_O      = rev_o;
  assign INPUT_SOURCE_TYPE_O   = src_o;
  assign TIMER_EXPIRED_FAULT_O = tfault;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [ALERT_W:0] low_run;
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      low_run <= '0;
    end else begin
      // a retrigger starts the width count afresh
      low_run <= alert_evt ? (ALERT_W + 1)'(1) :
                 alert_n   ? '0 : low_run + (ALERT_W + 1)'(1);
    end
  end

  sequence s_alert_low;
    !HOST_ALERT_N_O ##1 !HOST_ALERT_N_O;
  endsequence

  property p_fast_expiry;
    expire[2] |=> TIMER_EXPIRED_FAULT_O and s_alert_low;
  endproperty
  a_fast_expiry: assert property (p_fast_expiry)
    else $error("fast expiry without fault and alert");

  property p_pre_bound;
    // a select change clears one cycle late, so bound by the old select
    cnt[1] <= (psel_q ? CNT_W'(PRE_SHORT) : CNT_W'(PRE_LONG));
  endproperty
  a_pre_bound: assert property (p_pre_bound)
    else $error("pre-charge count beyond its duration");

  property p_off_zero;
    !on[2] |=> cnt[2] == '0;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("disabled fast timer not at zero");

  property p_freeze;
    (CHARGE_FAULT_I || SUPPLEMENT_I) && clr == 3'h0 && on == $past(on)
      |=> cnt[0] == $past(cnt[0]) && cnt[2] == $past(cnt[2]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("timer moved while suspended");

  property p_restart;
    restart |=> cnt[0] == '0 && cnt[1] == '0 && cnt[2] == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timers not cleared on cycle restart");

  property p_half_skip;
    tick && half && !half_ph && clr == 3'h0 |=> $stable(cnt[2]);
  endproperty
  a_half_skip: assert property (p_half_skip)
    else $error("half rate advanced on skipped tick");

  property p_bypass;
    bypass |=> zone_q == CSTZ_Z_NORMAL;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zone state not 000 under bypass");

  property p_zone_flag;
    zone_chg && zone_raw == CSTZ_Z_HOT |=> flags[3] && zone_q == CSTZ_Z_HOT;
  endproperty
  a_zone_flag: assert property (p_zone_flag)
    else $error("hot zone change not flagged");

  property p_otg_stop;
    otg_stop |=> !REVERSE_SWITCH_O && INPUT_SOURCE_TYPE_O == 3'h0;
  endproperty
  a_otg_stop: assert property (p_otg_stop)
    else $error("reverse output kept switching out of window");

  property p_alert_width;
    $rose(HOST_ALERT_N_O) |-> $past(low_run) == (ALERT_W + 1)'(ALERT_CYCLES);
  endproperty
  a_alert_width: assert property (p_alert_width)
    else $error("alert pulse width wrong");

endmodule

// *** sim/cstz_host_model.sv ***
// host side model: watches the alert line and measures each pulse
`timescale 1ns/1ps
module cstz_host_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic alert_n_i,
  output int        pulses_o,
  output int        width_o
);
  int run_len;

  // width kept whole so a short or stretched pulse shows up
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_len  <= 0;
      pulses_o <= 0;
      width_o  <= 0;
    end else if (alert_n_i === 1'b0) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      pulses_o <= pulses_o + 1;
      width_o  <= run_len;
      run_len  <= 0;
    end
  end
endmodule

// *** sim/test_charge_safety_timer_temp_zones.sv ***
// self-checking bench for the charge safety timer block
`timescale 1ns/1ps
module test_charge_safety_timer_temp_zones;
  import cstz_pkg::*;
  localparam int TK = 4;
  localparam int AL = 8;
  localparam int FT[4] = '{3, 4, 5, 6};
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0, rdata, v;
  logic [2:0] stage = '0, src = '0, src_o;
  logic       ce_n = 0, rech = 0, vin = 0, icl = 0, treg = 0;
  logic       flt = 0, sup = 0, cold = 0, cool = 0, warm = 0, hot = 0;
  logic       alert_n, susp, term, rev, tfault;
  logic [1:0] scale;
  int         fail_count = 0, checks_done = 0, cyc = 0, rsel, p0;
  int         pulses, width;

  cstz_safety_timer #(.TICK_CYCLES(TK), .ALERT_CYCLES(AL),
    .TRICKLE_TICKS(3), .PRE_LONG(5), .PRE_SHORT(2), .FAST_0(FT[0]),
    .FAST_1(FT[1]), .FAST_2(FT[2]), .FAST_3(FT[3])) i_cstz_safety_timer (
    .MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .CHG_STAGE_I(stage), .CE_N_I(ce_n), .RECHARGE_I(rech), .VIN_REG_I(vin),
    .INPUT_CURRENT_LIMIT_ACTIVE_I(icl), .THERMAL_REG_I(treg),
    .CHARGE_FAULT_I(flt), .SUPPLEMENT_I(sup), .TS_COLD_I(cold),
    .COOL_THRESHOLD_SEL_I(cool), .WARM_THRESHOLD_SEL_I(warm), .TS_HOT_I(hot), .SOURCE_TYPE_I(src),
    .HOST_ALERT_N_O(alert_n), .CHARGE_SUSPEND_O(susp),
    .CURRENT_SCALE_O(scale), .TERM_ALLOW_O(term), .REVERSE_SWITCH_O(rev),
    .INPUT_SOURCE_TYPE_O(src_o), .TIMER_EXPIRED_FAULT_O(tfault));

  cstz_host_model i_cstz_host_model (.clk_i(clk), .rst_n_i(rst_n),
    .alert_n_i(alert_n), .pulses_o(pulses), .width_o(width));

  // ----------------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // whole run is under a thousand cycles; far above that means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_reg(input logic on);
    @(posedge clk);
    vin  <= on && rsel == 0;
    icl  <= on && rsel == 1;
    treg <= on && rsel == 2;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // restart a cycle in a given stage, expect expiry after t ticks (0: none)
  task automatic run(input logic [2:0] stg, input logic [7:0] c0,
                     input int t, input int hold);
    int n;
    int lim;
    int sel;
    n   = 0;
    lim = (t == 0) ? 60 : t * TK + 20;
    sel = $urandom_range(0, 2);
    p0  = pulses;
    @(posedge clk);
    stage <= stg;
    // trickle runs freeze through supplement mode, the others by a fault
    flt   <= (hold > 0) && stg != 3'b001;
    sup   <= (hold > 0) && stg == 3'b001;
    // restart by bit toggle, pin toggle or recharge, same clearing edge
    if (sel == 0) wrr(4'h0, c0 & 8'hfe);
    wrr(4'h0, c0);
    if (sel == 1) begin
      ce_n <= 1'b1;
      @(posedge clk);
      ce_n <= 1'b0;
    end else if (sel == 2) begin
      rech <= 1'b1;
      @(posedge clk);
      rech <= 1'b0;
    end
    if (sel != 2) @(posedge clk);
    #1;
    repeat (hold) @(posedge clk);
    flt <= 1'b0;
    sup <= 1'b0;
    while (tfault !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (t == 0) begin
      chk("fault while disabled", 8'h0, {7'h0, tfault});
    end else begin
      checks_done++;
      if (n < (t - 2) * TK + 1 || n > t * TK + 2) begin
        fail_count++;
        $display("Error expiry cycles expected %0d..%0d seen %0d",
                 (t - 2) * TK + 1, t * TK + 2, n);
      end
      wait_cyc(AL + 3);
      chk("alert width", 8'(AL), 8'(width));
      chk("expiry alert", 8'(p0 + 1), 8'(pulses));
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(92727));
    rsel = $urandom_range(0, 2);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    src   <= 3'($urandom_range(1, 7));
    rdr(4'h0, v); chk("ctrl0 reset", 8'h9f, v);
    rdr(4'h1, v); chk("ctrl1 reset", 8'h05, v);
    rdr(4'h2, v); chk("zone reset", 8'h00, v & 8'h0f);
    rdr(4'h9, v); chk("unmapped read", 8'h00, v);
    for (int k = 0; k < 4; k++) begin
      run(3'b011, {2'(k), 1'($urandom), 5'h1f}, FT[k], 0);
    end
    run(3'b001, 8'h9f, 3, 0);
    run(3'b010, 8'h9f, 5, 0);
    run(3'b010, 8'hbf, 2, 0);
    run(3'b011, 8'h97, 0, 0);
    run(3'b011, 8'h9f, FT[2], 0);
    run(3'b011, 8'h9f, FT[2], 20 + $urandom_range(0, 9));
    run(3'b001, 8'h9f, 3, 16);
    set_reg(1'b1);
    run(3'b011, 8'h9f, 2 * FT[2], 0);
    run(3'b011, 8'h8f, 2 * FT[2], 0);
    set_reg(1'b0);
    set_reg(1'b1);
    run(3'b011, 8'h8f, FT[2], 0);
    set_reg(1'b0);
    rdr(4'h3, v);
    wrr(4'h1, 8'h25);
    p0 = pulses;
    @(posedge clk);
    hot <= 1'b1;
    wait_cyc(3);
    chk("reverse stopped", 8'h0, {7'h0, rev});
    chk("source forced", 8'h0, {5'h0, src_o});
    chk("hot scale", 8'h0, {6'h0, scale});
    chk("hot suspend", 8'h1, {7'h0, susp});
    rdr(4'h2, v); chk("zone hot", 8'h04, v & 8'h07);
    rdr(4'h3, v); chk("hot flag", 8'h08, v & 8'h0f);
    rdr(4'h3, v); chk("flag cleared", 8'h00, v & 8'h0f);
    wait_cyc(AL + 3);
    chk("zone alert", 8'(p0 + 1), 8'(pulses));
    @(posedge clk);
    hot <= 1'b0;
    wait_cyc(3);
    chk("reverse resumed", 8'h1, {7'h0, rev});
    chk("source passed", {5'h0, src}, {5'h0, src_o});
    wrr(4'h1, 8'h35);
    wait_cyc(AL + 3);
    p0 = pulses;
    @(posedge clk);
    cold <= 1'b1;
    wait_cyc(AL + 3);
    chk("masked alert", 8'(p0), 8'(pulses));
    rdr(4'h2, v); chk("zone cold", 8'h01, v & 8'h07);
    cold <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      wrr(4'h1, 8'(s) | (s[0] ? 8'h04 : 8'h00));
      @(posedge clk);
      cool <= 1'b1;
      wait_cyc(3);
      chk("cool scale", 8'(s), {6'h0, scale});
      chk("cool term", 8'(s[0]), {7'h0, term});
      @(posedge clk);
      cool <= 1'b0;
      wait_cyc(3);
    end
    wrr(4'h1, 8'h0d);
    @(posedge clk);
    hot <= 1'b1;
    wait_cyc(3);
    rdr(4'h2, v); chk("bypass zone", 8'h00, v & 8'h07);
    chk("bypass scale", 8'h3, {6'h0, scale});
    end_sim();
  end
endmodule
